/* common/scidx_consts.svh */
// Operation
// - one written means set, zero means cleared
// - setup resets 0x18, most significant first
// - part identifier is read-only, writes ignored
// - grade code reported in bits 5:4
// - upper index bits select channels H-E
// - lower index bits select channels D-A
// - lower bits 5,4 select data/frame clock
// - setup, index, update registers act immediately
// - any reset loads documented defaults
`ifndef SCIDX_CONSTS_SVH
`define SCIDX_CONSTS_SVH

// register addresses on the 13-bit address field
`define SCIDX_ADDR_SETUP 13'h0000
`define SCIDX_ADDR_ID 13'h0001
`define SCIDX_ADDR_GRADE 13'h0002
`define SCIDX_ADDR_UPPER 13'h0004
`define SCIDX_ADDR_LOWER 13'h0005
`define SCIDX_ADDR_UPDATE 13'h00FF

// port setup field positions
`define SCIDX_SETUP_LSB_HI 6
`define SCIDX_SETUP_LSB_LO 1
`define SCIDX_SETUP_SRST_HI 5
`define SCIDX_SETUP_SRST_LO 2
`define SCIDX_SETUP_RESET 8'h18

// index register fields and reset values
`define SCIDX_LOWER_DATA_CLK 5
`define SCIDX_LOWER_FRAME_CLK 4
`define SCIDX_UPPER_RESET 8'h0F
`define SCIDX_LOWER_RESET 8'h0F
`define SCIDX_UPDATE_XFER 0

// grade field position
`define SCIDX_GRADE_LSB 4

// frame timing in serial clock bits
`define SCIDX_INSTR_LAST 4'hF
`define SCIDX_BYTE_LAST 4'h7
`define SCIDX_STREAM 2'h3

`endif

/* common/scidx_pkg.sv */
`default_nettype none
package scidx_pkg;
   // serial frame phase
   typedef enum logic [1:0] {
      ST_INSTR = 2'b00,
      ST_DATA = 2'b01,
      ST_DONE = 2'b10
   } scidx_state_e;

   // 16-bit instruction word
   typedef struct packed {
      logic rw;
      logic [1:0] w;
      logic [12:0] addr;
   } scidx_instr_s;

   // write-target selection carried to the channels
   typedef struct packed {
      logic data_clock_output; // data clock output as write target
      logic frame_clock_output; // frame clock output as write target
      logic [7:0] data;
   } scidx_sel_s;
endpackage
`default_nettype wire

/* hdl/scidx_regbank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scidx_consts.svh"
module scidx_regbank #(
   parameter logic [7:0] PART_ID = 8'hA5, // arbitrary value
   parameter logic [1:0] SPEED_GRADE = 2'h0 // grade code, plain default
) (
   input wire logic MCLK_I,
   input wire logic SRST_I,
   input wire logic SCLK_I,
   input wire logic CSB_N_I,
   input wire logic SDIO_I,
   output logic SDIO_O,
   output logic SDIO_OE_O,
   output logic LSB_FIRST_O,
   output logic TRANSFER_O,
   output scidx_pkg::scidx_sel_s SEL_O
);
   // pin synchronisers, stage 1 read only by stage 2
   logic [2:0] sclk_q;
   logic [1:0] csb_q;
   logic [1:0] sdio_q;
   logic rise; // serial clock rising edge
   logic fall; // serial clock falling edge
   logic cs; // frame active
   logic din; // synchronised data in

   // frame state
   scidx_pkg::scidx_state_e state, next_state;
   logic [3:0] cnt, next_cnt; // bit within instruction or byte
   logic [15:0] sh, next_sh; // input shifter
   scidx_pkg::scidx_instr_s instr, next_instr;
   logic [1:0] left, next_left; // bytes remaining after current
   logic [7:0] tx, next_tx; // byte being read back
   logic next_sdio, next_oe;
   logic next_lsb, next_xfer;
   scidx_pkg::scidx_sel_s next_sel;
   logic wr_stb; // a data byte is written this cycle
   logic [7:0] wr_data; // the written byte
   logic [12:0] step; // following address
   localparam logic [7:0] upper_rst = `SCIDX_UPPER_RESET; // channels h-e default
   localparam logic [7:0] lower_rst = `SCIDX_LOWER_RESET; // channels d-a and clock defaults

   // synchroniser chain
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         sclk_q <= 3'h0;
         csb_q <= 2'h3;
         sdio_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], SCLK_I};
         csb_q <= {csb_q[0], CSB_N_I};
         sdio_q <= {sdio_q[0], SDIO_I};
      end
   end

   // edges from stages 2 and 3 only
   assign rise = sclk_q[1] & ~sclk_q[2];
   assign fall = ~sclk_q[1] & sclk_q[2];
   assign cs = ~csb_q[1];
   assign din = sdio_q[1];

   // readback mux
   function automatic logic [7:0] rd_mux(input logic [12:0] a);
      case (a)
         `SCIDX_ADDR_SETUP: rd_mux = {1'b0, LSB_FIRST_O, 1'b0, 2'h3, 1'b0, LSB_FIRST_O, 1'b0};
         `SCIDX_ADDR_ID: rd_mux = PART_ID;
         `SCIDX_ADDR_GRADE: rd_mux = {2'h0, SPEED_GRADE, 4'h0};
         `SCIDX_ADDR_UPPER: rd_mux = {4'h0, SEL_O.data[7:4]};
         `SCIDX_ADDR_LOWER: rd_mux = {2'h0, SEL_O.data_clock_output, SEL_O.frame_clock_output, SEL_O.data[3:0]};
         default: rd_mux = 8'h00; // unmapped and update read zero
      endcase
   endfunction

   // address walks down msb-first, up lsb-first
   assign step = LSB_FIRST_O ? instr.addr + 13'h0001 : instr.addr - 13'h0001;

   // next-value logic for frame and registers
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_instr = instr;
      next_left = left;
      next_tx = tx;
      next_sdio = SDIO_O;
      next_lsb = LSB_FIRST_O;
      next_sel = SEL_O;
      next_xfer = 1'b0;
      wr_stb = 1'b0;
      wr_data = 8'h00;
      if (!cs) begin
         // stall between bytes keeps a non-streaming frame, else restart
         if (!(state == scidx_pkg::ST_DATA && cnt == 4'h0 && instr.w != `SCIDX_STREAM)) begin
            next_state = scidx_pkg::ST_INSTR;
            next_cnt = 4'h0;
         end
      end else if (rise) begin
         // shift one bit in
         next_cnt = cnt + 4'h1;
         if (!LSB_FIRST_O) begin
            next_sh = {sh[14:0], din};
         end else if (state == scidx_pkg::ST_INSTR) begin
            next_sh = {din, sh[15:1]};
         end else begin
            next_sh = {8'h00, din, sh[7:1]};
         end
         case (state)
            scidx_pkg::ST_INSTR: begin
               if (cnt == `SCIDX_INSTR_LAST) begin
                  next_instr = scidx_pkg::scidx_instr_s'(next_sh);
                  next_state = scidx_pkg::ST_DATA;
                  next_cnt = 4'h0;
                  next_left = next_sh[14:13];
                  next_tx = rd_mux(next_sh[12:0]);
               end
            end
            scidx_pkg::ST_DATA: begin
               if (cnt == `SCIDX_BYTE_LAST) begin
                  next_cnt = 4'h0;
                  wr_stb = ~instr.rw;
                  wr_data = next_sh[7:0];
                  next_instr.addr = step;
                  next_tx = rd_mux(step);
                  if (instr.w != `SCIDX_STREAM) begin
                     if (left == 2'h0) begin
                        next_state = scidx_pkg::ST_DONE;
                     end else begin
                        next_left = left - 2'h1;
                     end
                  end
               end
            end
            default: begin
               next_cnt = cnt; // frame over, ignore bits
            end
         endcase
      end else if (fall && state == scidx_pkg::ST_DATA && instr.rw) begin
         // drive next readback bit on falling edge
         next_sdio = LSB_FIRST_O ? tx[cnt[2:0]] : tx[3'h7 - cnt[2:0]];
      end
      // register writes take effect at once
      if (wr_stb) begin
         case (instr.addr)
            `SCIDX_ADDR_SETUP: begin
               next_lsb = wr_data[`SCIDX_SETUP_LSB_HI] | wr_data[`SCIDX_SETUP_LSB_LO];
               if (wr_data[`SCIDX_SETUP_SRST_HI] | wr_data[`SCIDX_SETUP_SRST_LO]) begin
                  // soft reset: defaults, nothing stored
                  next_lsb = 1'b0;
                  next_sel.data = {upper_rst[3:0], lower_rst[3:0]};
                  next_sel.data_clock_output = lower_rst[`SCIDX_LOWER_DATA_CLK];
                  next_sel.frame_clock_output = lower_rst[`SCIDX_LOWER_FRAME_CLK];
               end
            end
            `SCIDX_ADDR_UPPER: begin
               next_sel.data[7:4] = wr_data[3:0];
            end
            `SCIDX_ADDR_LOWER: begin
               next_sel.data[3:0] = wr_data[3:0];
               next_sel.data_clock_output = wr_data[`SCIDX_LOWER_DATA_CLK];
               next_sel.frame_clock_output = wr_data[`SCIDX_LOWER_FRAME_CLK];
            end
            `SCIDX_ADDR_UPDATE: begin
               next_xfer = wr_data[`SCIDX_UPDATE_XFER];
            end
            default: begin
               next_xfer = 1'b0; // read-only or unmapped, ignored
            end
         endcase
      end
      next_oe = cs && next_state == scidx_pkg::ST_DATA && next_instr.rw;
   end

   // registers, defaults on reset
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         state <= scidx_pkg::ST_INSTR;
         cnt <= 4'h0;
         sh <= 16'h0000;
         instr <= '0;
         left <= 2'h0;
         tx <= 8'h00;
         SDIO_O <= 1'b0;
         SDIO_OE_O <= 1'b0;
         LSB_FIRST_O <= 1'b0;
         TRANSFER_O <= 1'b0;
         SEL_O.data <= {upper_rst[3:0], lower_rst[3:0]};
         SEL_O.data_clock_output <= lower_rst[`SCIDX_LOWER_DATA_CLK];
         SEL_O.frame_clock_output <= lower_rst[`SCIDX_LOWER_FRAME_CLK];
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         instr <= next_instr;
         left <= next_left;
         tx <= next_tx;
         SDIO_O <= next_sdio;
         SDIO_OE_O <= next_oe;
         LSB_FIRST_O <= next_lsb;
         TRANSFER_O <= next_xfer;
         SEL_O <= next_sel;
      end
   end

   // checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SRST_I);

   a_softrst_defaults: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_SETUP && (wr_data[5] | wr_data[2])
      |=> (!LSB_FIRST_O && SEL_O == 10'h0FF) [*2])
      else $error("soft reset did not restore defaults");
   a_lsb_mirror: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_SETUP && !(wr_data[5] | wr_data[2])
      |=> LSB_FIRST_O == ($past(wr_data[6]) | $past(wr_data[1])))
      else $error("bit order not decoded from mirrored nibbles");
   a_setup_fixed: assert property (
      (rd_mux(`SCIDX_ADDR_SETUP) & 8'h99) == 8'h18)
      else $error("setup fixed bits wrong");
   a_id_readonly: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_ID |=> $stable(SEL_O) && $stable(LSB_FIRST_O) && !TRANSFER_O)
      else $error("write to part identifier had an effect");
   a_grade_field: assert property (
      next_state == scidx_pkg::ST_DATA && state == scidx_pkg::ST_INSTR && next_sh[12:0] == `SCIDX_ADDR_GRADE
      |=> tx == {2'h0, SPEED_GRADE, 4'h0})
      else $error("grade readback wrong");
   a_upper_sel: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_UPPER |=> SEL_O.data[7:4] == $past(wr_data[3:0]) && $stable(SEL_O.data[3:0]))
      else $error("upper channel select not written");
   a_lower_sel: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_LOWER |=> SEL_O.data[3:0] == $past(wr_data[3:0]) && $stable(SEL_O.data[7:4]))
      else $error("lower channel select not written");
   a_clock_sel: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_LOWER
      |=> {SEL_O.data_clock_output, SEL_O.frame_clock_output} == $past(wr_data[5:4]))
      else $error("clock channel select not written");
   a_xfer_pulse: assert property (
      wr_stb && instr.addr == `SCIDX_ADDR_UPDATE && wr_data[0] |=> TRANSFER_O ##1 !TRANSFER_O)
      else $error("transfer pulse wrong");

   c_read_frame: cover property (state == scidx_pkg::ST_DATA && instr.rw && SDIO_OE_O);
   c_stream_write: cover property (wr_stb && instr.w == `SCIDX_STREAM ##[1:300] wr_stb);
   c_soft_reset: cover property (wr_stb && instr.addr == `SCIDX_ADDR_SETUP && wr_data[5]);
   c_lsb_mode: cover property (LSB_FIRST_O && wr_stb);
endmodule
`default_nettype wire

/* bench/scidx_host.sv */
`timescale 1ns/1ps
`default_nettype none
// serial host: three-wire port master, clock still outside frames
module scidx_host (
   input wire logic clk_i,
   input wire logic sdi_i,
   output logic sclk_o,
   output logic csb_n_o,
   output logic sdo_o
);
   initial begin
      sclk_o = 1'b0;
      csb_n_o = 1'b1;
      sdo_o = 1'b0;
   end
   // wait n clocks, land just after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // one single-byte frame, lsb picks shift order
   task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                        input logic lsb, output logic [7:0] rdat);
      logic [23:0] sh;
      logic b;
      sh = lsb ? {<<{wd, rd, 2'b00, addr}} : {rd, 2'b00, addr, wd};
      rdat = 8'h00;
      csb_n_o = 1'b0;
      tick(6);
      for (int i = 0; i < 24; i++) begin
         // released data line flips each bit, never holds
         sdo_o = (i < 16 || !rd) ? sh[23-i] : ~sdo_o;
         tick(6);
         sclk_o = 1'b1;
         b = sdi_i;
         rdat = lsb ? {b, rdat[7:1]} : {rdat[6:0], b};
         tick(6);
         sclk_o = 1'b0;
      end
      tick(6);
      csb_n_o = 1'b1;
      sdo_o = ~sdo_o;
      tick(6);
   endtask
   // two-byte msb-first write, second byte lands one address down
   task automatic pair(input logic [12:0] addr, input logic [7:0] b0, input logic [7:0] b1);
      logic [31:0] sh;
      sh = {1'b0, 2'b01, addr, b0, b1};
      csb_n_o = 1'b0;
      tick(6);
      for (int i = 0; i < 32; i++) begin
         sdo_o = sh[31-i];
         tick(6);
         sclk_o = 1'b1;
         tick(6);
         sclk_o = 1'b0;
      end
      tick(6);
      csb_n_o = 1'b1;
      sdo_o = ~sdo_o;
      tick(6);
   endtask
endmodule
`default_nettype wire

/* bench/scidx_regbank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module scidx_regbank_tb;
   typedef struct packed {
      logic [12:0] a;
      logic [7:0] wd;
      logic [9:0] sel;
      logic [7:0] rd;
   } scidx_row_s;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic sclk, csb_n, sdo, sdio_o, sdio_oe, lsb_first, transfer;
   scidx_pkg::scidx_sel_s sel;
   int error_cnt = 0;
   int n_compared = 0;
   int xfer_cnt = 0;
   logic [7:0] rd;
   scidx_row_s rows [6];
   // device wins the data line while it drives
   wire logic sdio_w = sdio_oe ? sdio_o : sdo;
   always #20 mclk = ~mclk;
   scidx_regbank DUT (.MCLK_I(mclk), .SRST_I(srst), .SCLK_I(sclk), .CSB_N_I(csb_n),
      .SDIO_I(sdio_w), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .LSB_FIRST_O(lsb_first),
      .TRANSFER_O(transfer), .SEL_O(sel));
   scidx_host HOST (.clk_i(mclk), .sdi_i(sdio_w), .sclk_o(sclk), .csb_n_o(csb_n), .sdo_o(sdo));
   // count transfer pulses
   always @(posedge mclk) begin
      if (transfer === 1'b1) xfer_cnt <= xfer_cnt + 1;
   end
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // watchdog, about four times the expected run
   initial begin
      #1_000_000;
      error_cnt++;
      conclude();
   end
   initial begin
      // write/readback rows: addr, data, sel after, readback
      rows[0] = '{13'h0005, 8'h3A, 10'h3FA, 8'h3A};
      rows[1] = '{13'h0004, 8'h05, 10'h35A, 8'h05};
      rows[2] = '{13'h0005, 8'h20, 10'h250, 8'h20};
      rows[3] = '{13'h0001, 8'hFF, 10'h250, 8'hA5};
      rows[4] = '{13'h0002, 8'hFF, 10'h250, 8'h00};
      rows[5] = '{13'h0000, 8'h18, 10'h250, 8'h18}; // mirrored
      HOST.tick(16);
      srst = 1'b0;
      chk("sel", sel, 10'h0FF);
      chk("lsb", {9'h0, lsb_first}, 10'h000);
      chk("oe", {9'h0, sdio_oe}, 10'h000);
      HOST.tick(3);
      HOST.frame(1'b1, 13'h0000, 8'h00, 1'b0, rd);
      chk("setup", {2'b00, rd}, 10'h018);
      chk("oe", {9'h0, sdio_oe}, 10'h000);
      foreach (rows[i]) begin
         HOST.frame(1'b0, rows[i].a, rows[i].wd, 1'b0, rd);
         chk("sel", sel, rows[i].sel);
         HOST.frame(1'b1, rows[i].a, 8'h00, 1'b0, rd);
         chk("read", {2'b00, rd}, {2'b00, rows[i].rd});
      end
      // soft reset through both mirrored bits
      HOST.frame(1'b0, 13'h0000, 8'h3C, 1'b0, rd);
      chk("sel", sel, 10'h0FF);
      HOST.frame(1'b1, 13'h0000, 8'h00, 1'b0, rd);
      chk("setup", {2'b00, rd}, 10'h018);
      // least significant first, then index and update writes
      HOST.frame(1'b0, 13'h0000, 8'h5A, 1'b0, rd);
      chk("lsb", {9'h0, lsb_first}, 10'h001);
      HOST.frame(1'b0, 13'h0005, 8'h10, 1'b1, rd);
      chk("sel", sel, 10'h1F0);
      HOST.frame(1'b1, 13'h0005, 8'h00, 1'b1, rd);
      chk("read", {2'b00, rd}, 10'h010);
      HOST.frame(1'b0, 13'h00FF, 8'h01, 1'b1, rd);
      chk("xfer", 10'(xfer_cnt), 10'h001);
      HOST.frame(1'b0, 13'h0000, 8'h18, 1'b1, rd);
      chk("lsb", {9'h0, lsb_first}, 10'h000);
      // reset in mid-run restores the index defaults
      HOST.pair(13'h0005, 8'h2C, 8'h03);
      chk("sel", sel, 10'h23C);
      HOST.frame(1'b0, 13'h0004, 8'h00, 1'b0, rd);
      chk("sel", sel, 10'h20C);
      srst = 1'b1;
      HOST.tick(3);
      srst = 1'b0;
      HOST.tick(1);
      chk("sel", sel, 10'h0FF);
      conclude();
   end
endmodule
`default_nettype wire
